//--- shared/wisd_pkg.sv
// Package: constants, register map and types of the weighted integration discriminator
package wisd_pkg;
  localparam int SAMPLE_W = 16;
  localparam int WEIGHT_W = 16;
  localparam int WDEPTH = 4096;
  localparam int WADDR_W = 12;
  localparam int NUNIT = 4;
  localparam int UIDX_W = 2;
  localparam int PROD_W = SAMPLE_W + WEIGHT_W + 1;
  localparam int ACC_W = PROD_W + WADDR_W + 1;
  localparam int FIFO_DEPTH = 8;
  localparam int LOG_W = ACC_W;
  localparam int NCO_W = 10;
  // Register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_LEN = 8'h04;
  localparam logic [7:0] REG_DSF = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_WADDR = 8'h10;
  localparam logic [7:0] REG_WDATA = 8'h14;
  localparam logic [7:0] REG_ASSIGN = 8'h18;
  localparam logic [7:0] REG_NCOINC = 8'h1C;
  localparam logic [7:0] REG_THR0 = 8'h20;
  localparam logic [7:0] REG_STATE = 8'h30;
  // Control fields
  localparam int CTRL_START = 0;
  localparam int CTRL_LRO = 1;
  localparam int CTRL_MULTI = 2;
  localparam int CTRL_SRC_INT = 3;
  localparam int CTRL_NSTATE = 4;
  // Reset values and downsampling factor limits
  localparam logic [WADDR_W:0] LEN_RST = 13'h0010;
  localparam logic [4:0] DSF_RST = 5'h01;
  localparam logic [4:0] DSF_MIN = 5'h01;
  localparam logic [4:0] DSF_MAX = 5'h10;
  localparam logic [1:0] ASSIGN_RST = 2'h1;
  localparam logic [NCO_W-1:0] NCO_RST = 10'h000;
  typedef enum logic [1:0] {
    WISD_IDLE = 2'b00,
    WISD_INTEG = 2'b01,
    WISD_DISC = 2'b11,
    WISD_LOG = 2'b10
  } wisd_state_t;
endpackage

//--- hdl/wisd_fifo.sv
// Synchronous FIFO with registered read data
`timescale 1ns/1ps
module wisd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;
  logic out_valid_q;
  logic [WIDTH-1:0] out_data_q;
  logic take;
  // Output register is not counted in cnt_q, so it holds one entry beyond DEPTH
  assign in_ready = cnt_q != (AW+1)'(DEPTH) ? 1'b1 : 1'b0;
  assign push = in_valid && in_ready;
  assign take = !out_valid_q || out_ready;
  assign pop = take && (cnt_q != '0);
  assign out_valid = out_valid_q;
  assign out_data = out_data_q;
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= AW'(wr_q + 1'b1);
      end
      if (pop) begin
        rd_q <= AW'(rd_q + 1'b1);
      end
      cnt_q <= (AW+1)'(cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    end
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      out_valid_q <= 1'b0;
      out_data_q <= '0;
    end else if (take) begin
      out_valid_q <= pop;
      if (pop) begin
        out_data_q <= mem[rd_q];
      end
    end
  end
endmodule

//--- hdl/wisd_core.sv
// Weighted integration, thresholding, assignment and result logging
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/1ps
module wisd_core (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [wisd_pkg::SAMPLE_W-1:0] smp_re,
  input wire logic [wisd_pkg::SAMPLE_W-1:0] smp_im,
  input wire logic smp_valid,
  output logic [wisd_pkg::LOG_W-1:0] log_data,
  output logic [wisd_pkg::UIDX_W-1:0] log_unit,
  output logic log_valid,
  input wire logic log_ready,
  output logic [wisd_pkg::NUNIT-1:0] state_bits,
  output logic busy
);
  import wisd_pkg::*;

  logic signed [SAMPLE_W-1:0] s_re_q;
  logic signed [SAMPLE_W-1:0] s_im_q;
  logic s_val_q;
  logic ctrl_lro_q;
  logic ctrl_multi_q;
  logic ctrl_src_q;
  logic [1:0] ctrl_nst_q;
  logic start_q;
  logic [WADDR_W:0] len_q;
  logic [4:0] dsf_q;
  logic [WADDR_W+UIDX_W-1:0] waddr_q;
  logic [NCO_W-1:0] nco_inc_q;
  logic [NCO_W-1:0] nco_ph_q;
  logic [NUNIT-1:0] assign_q;
  logic signed [ACC_W-1:0] thr_q [NUNIT];
  logic signed [ACC_W-1:0] acc_q [NUNIT];
  logic signed [ACC_W-1:0] res [NUNIT];
  logic [WADDR_W-1:0] widx_nx;
  logic [2*WEIGHT_W-1:0] wmem [NUNIT*WDEPTH];
  logic [2*WEIGHT_W-1:0] w_q [NUNIT];
  logic [WADDR_W:0] cnt_q;
  logic [WADDR_W-1:0] widx_q;
  logic [4:0] ds_q;
  logic [NUNIT-1:0] state_q;
  logic [UIDX_W-1:0] lidx_q;
  logic [UIDX_W:0] nlog;
  logic [31:0] rdata_q;
  logic fin_q;
  logic lf_in_valid;
  logic lf_in_ready;
  logic signed [SAMPLE_W-1:0] d_re;
  logic signed [SAMPLE_W-1:0] d_im;
  logic step;
  wisd_state_t st_q;

  // Complex product real and imaginary parts, full width
  function automatic logic signed [PROD_W-1:0] cmul_re(
    input logic signed [SAMPLE_W-1:0] ar, input logic signed [SAMPLE_W-1:0] ai,
    input logic signed [WEIGHT_W-1:0] br, input logic signed [WEIGHT_W-1:0] bi);
    cmul_re = PROD_W'(ar * br) - PROD_W'(ai * bi);
  endfunction

  function automatic logic signed [PROD_W-1:0] cmul_im(
    input logic signed [SAMPLE_W-1:0] ar, input logic signed [SAMPLE_W-1:0] ai,
    input logic signed [WEIGHT_W-1:0] br, input logic signed [WEIGHT_W-1:0] bi);
    cmul_im = PROD_W'(ar * bi) + PROD_W'(ai * br);
  endfunction

  // Samples come from the converter domain, two stages before use
  logic [2*SAMPLE_W:0] in_m_q;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      in_m_q <= '0;
      {s_val_q, s_re_q, s_im_q} <= '0;
    end else begin
      in_m_q <= {smp_valid, smp_re, smp_im};
      {s_val_q, s_re_q, s_im_q} <= in_m_q;
    end
  end

  // Register writes
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctrl_lro_q <= 1'b0;
      ctrl_multi_q <= 1'b0;
      ctrl_src_q <= 1'b1;
      ctrl_nst_q <= 2'h2;
      start_q <= 1'b0;
      len_q <= LEN_RST;
      dsf_q <= DSF_RST;
      waddr_q <= '0;
      nco_inc_q <= NCO_RST;
      assign_q <= {NUNIT{ASSIGN_RST[0]}};
      for (int k = 0; k < NUNIT; k++) begin
        thr_q[k] <= '0;
      end
    end else begin
      start_q <= 1'b0;
      if (reg_wr) begin
        case (reg_addr)
          REG_CTRL: begin
            start_q <= reg_wdata[CTRL_START] && st_q == WISD_IDLE;
            ctrl_lro_q <= reg_wdata[CTRL_LRO];
            ctrl_multi_q <= reg_wdata[CTRL_MULTI];
            ctrl_src_q <= reg_wdata[CTRL_SRC_INT];
            ctrl_nst_q <= reg_wdata[CTRL_NSTATE+:2];
          end
          // Lengths beyond the weight depth are clipped
          REG_LEN: len_q <= reg_wdata[WADDR_W:0] > (WADDR_W+1)'(WDEPTH) ?
            (WADDR_W+1)'(WDEPTH) : reg_wdata[WADDR_W:0];
          REG_DSF: begin
            if (reg_wdata[4:0] < DSF_MIN) begin
              dsf_q <= DSF_MIN;
            end else if (reg_wdata[4:0] > DSF_MAX) begin
              dsf_q <= DSF_MAX;
            end else begin
              dsf_q <= reg_wdata[4:0];
            end
          end
          REG_WADDR: waddr_q <= reg_wdata[WADDR_W+UIDX_W-1:0];
          REG_WDATA: waddr_q <= (WADDR_W+UIDX_W)'(waddr_q + 1'b1);
          REG_ASSIGN: assign_q <= reg_wdata[NUNIT-1:0];
          REG_NCOINC: nco_inc_q <= reg_wdata[NCO_W-1:0];
          default: begin
            for (int k = 0; k < NUNIT; k++) begin
              if (reg_addr == REG_THR0 + 8'(4 * k)) begin
                thr_q[k] <= ACC_W'(signed'(reg_wdata));
              end
            end
          end
        endcase
      end
    end
  end

  // Weight memory: no reset or initial value, so entries of each unit that are not written stay undefined
  always_ff @(posedge mclk) begin
    if (reg_wr && reg_addr == REG_WDATA) begin
      wmem[waddr_q] <= reg_wdata;
    end
  end

  // Demodulation oscillator, a coarse quadrant rotator for phase-only weights
  always_comb begin
    case (nco_ph_q[NCO_W-1 -: 2])
      2'd0: begin d_re = s_re_q; d_im = s_im_q; end
      2'd1: begin d_re = s_im_q; d_im = -s_re_q; end
      2'd2: begin d_re = -s_re_q; d_im = -s_im_q; end
      default: begin d_re = -s_im_q; d_im = s_re_q; end
    endcase
    if (!ctrl_lro_q) begin
      d_re = s_re_q;
      d_im = s_im_q;
    end
  end

  // Downsampling: modulated mode integrates every dsf-th demodulated sample
  assign step = s_val_q && st_q == WISD_INTEG && (!ctrl_lro_q || ds_q == 5'd1);

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      nco_ph_q <= '0;
      ds_q <= DSF_RST;
    end else begin
      if (s_val_q && ctrl_lro_q) begin
        nco_ph_q <= NCO_W'(nco_ph_q + nco_inc_q);
      end
      if (st_q != WISD_INTEG) begin
        ds_q <= dsf_q;
      end else if (s_val_q) begin
        ds_q <= ds_q == 5'd1 ? dsf_q : 5'(ds_q - 1'b1);
      end
    end
  end

  // Weight fetch, one sample ahead of accumulation, so back-to-back steps see fresh weights
  assign widx_nx = st_q == WISD_IDLE ? '0 : (step ? WADDR_W'(widx_q + 1'b1) : widx_q);
  always_ff @(posedge mclk) begin
    for (int k = 0; k < NUNIT; k++) begin
      w_q[k] <= wmem[{UIDX_W'(k), widx_nx}];
    end
  end

  // Sequencer
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_q <= WISD_IDLE;
      cnt_q <= '0;
      widx_q <= '0;
      lidx_q <= '0;
      fin_q <= 1'b0;
    end else begin
      case (st_q)
        WISD_IDLE: begin
          widx_q <= '0;
          cnt_q <= '0;
          if (start_q) begin
            st_q <= WISD_INTEG;
          end
        end
        WISD_INTEG: begin
          if (step) begin
            widx_q <= WADDR_W'(widx_q + 1'b1);
            cnt_q <= (WADDR_W+1)'(cnt_q + 1'b1);
            if ((WADDR_W+1)'(cnt_q + 1'b1) >= len_q) begin
              st_q <= WISD_DISC;
            end
          end
        end
        WISD_DISC: begin
          lidx_q <= '0;
          st_q <= WISD_LOG;
        end
        WISD_LOG: begin
          if (!ctrl_src_q) begin
            st_q <= WISD_IDLE;
          end else if (lf_in_ready) begin
            lidx_q <= UIDX_W'(lidx_q + 1'b1);
            if ((UIDX_W+1)'(lidx_q) + 1'b1 >= nlog) begin
              st_q <= WISD_IDLE;
            end
          end
        end
        default: st_q <= WISD_IDLE;
      endcase
    end
  end

  // Accumulators, wide enough for the full weight depth
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      for (int k = 0; k < NUNIT; k++) begin
        acc_q[k] <= '0;
      end
    end else if (start_q) begin
      for (int k = 0; k < NUNIT; k++) begin
        acc_q[k] <= '0;
      end
    end else if (step) begin
      for (int k = 0; k < NUNIT; k++) begin
        acc_q[k] <= acc_q[k] + ACC_W'(cmul_re(d_re, d_im, w_q[k][2*WEIGHT_W-1 -: WEIGHT_W],
          w_q[k][WEIGHT_W-1:0]));
      end
    end
  end

  // Three-state multistate derives unlogged unit 2 as the difference of units 1 and 0
  always_comb begin
    for (int k = 0; k < NUNIT; k++) begin
      res[k] = acc_q[k];
    end
    if (ctrl_multi_q && ctrl_nst_q == 2'h3) begin
      res[2] = acc_q[1] - acc_q[0];
    end
  end

  // Threshold and assignment
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_q <= '0;
    end else if (st_q == WISD_DISC) begin
      for (int k = 0; k < NUNIT; k++) begin
        // Bit 0 for at or below threshold, then mapped through the assignment bit
        state_q[k] <= (res[k] > thr_q[k]) ^ assign_q[k];
      end
    end
  end

  // Two-state logs all units; n-state logs only n-1 uploaded units
  assign nlog = ctrl_multi_q ? (UIDX_W+1)'(ctrl_nst_q) - 1'b1 : (UIDX_W+1)'(NUNIT);
  assign lf_in_valid = st_q == WISD_LOG && ctrl_src_q;

  wisd_fifo #(
    .WIDTH(LOG_W + UIDX_W),
    .DEPTH(FIFO_DEPTH)
  ) u_log_fifo (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .in_data({lidx_q, acc_q[lidx_q]}),
    .in_valid(lf_in_valid),
    .in_ready(lf_in_ready),
    .out_data({log_unit, log_data}),
    .out_valid(log_valid),
    .out_ready(log_ready)
  );

  // Register reads, data one cycle after the strobe
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdata_q <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_CTRL: rdata_q <= {26'h0, ctrl_nst_q, ctrl_src_q, ctrl_multi_q, ctrl_lro_q, 1'b0};
        REG_LEN: rdata_q <= 32'(len_q);
        REG_DSF: rdata_q <= 32'(dsf_q);
        REG_STATUS: rdata_q <= {28'h0, lf_in_ready, log_valid, st_q};
        REG_WADDR: rdata_q <= 32'(waddr_q);
        REG_ASSIGN: rdata_q <= 32'(assign_q);
        REG_NCOINC: rdata_q <= 32'(nco_inc_q);
        REG_STATE: rdata_q <= 32'(state_q);
        default: rdata_q <= 32'h0000_0000;
      endcase
    end else begin
      rdata_q <= '0;
    end
  end

  assign reg_rdata = rdata_q;
  assign state_bits = state_q;
  assign busy = st_q != WISD_IDLE;
endmodule

//--- sim/wisd_core_props.sv
// Concurrent checks on the ports of the weighted integration discriminator
`timescale 1ns/1ps
module wisd_core_props
  import wisd_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [SAMPLE_W-1:0] smp_re,
  input wire logic [SAMPLE_W-1:0] smp_im,
  input wire logic smp_valid,
  input wire logic [LOG_W-1:0] log_data,
  input wire logic [UIDX_W-1:0] log_unit,
  input wire logic log_valid,
  input wire logic log_ready,
  input wire logic [NUNIT-1:0] state_bits,
  input wire logic busy
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_rdata_quiet: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data not zero outside a read");
  a_reset_idle: assert property ($fell(sys_rst) |-> !busy && !log_valid && state_bits == 4'h0)
    else $error("outputs not idle after reset");
  a_start_busy: assert property (reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_START] && !busy
    |=> ##[0:2] busy)
    else $error("start did not make the block busy");
  a_log_hold: assert property (log_valid && !log_ready
    |=> log_valid && $stable(log_data) && $stable(log_unit))
    else $error("log entry dropped or changed while stalled");
  a_log_cause: assert property ($rose(log_valid) |-> busy || $past(busy) || $past(busy, 2))
    else $error("log entry without an integration");
  a_state_busy: assert property (!$stable(state_bits) |-> $past(busy))
    else $error("state bits changed while idle");
  a_state_read: assert property (reg_rd && reg_addr == REG_STATE
    |=> reg_rdata[NUNIT-1:0] == $past(state_bits))
    else $error("state register differs from state bits");
  a_status_read: assert property (reg_rd && reg_addr == REG_STATUS
    |=> reg_rdata[2] == $past(log_valid) && ((reg_rdata[1:0] == 2'b00) == !$past(busy)))
    else $error("status register inconsistent");
  a_dsf_range: assert property (reg_rd && reg_addr == REG_DSF
    |=> reg_rdata[4:0] >= DSF_MIN && reg_rdata[4:0] <= DSF_MAX)
    else $error("downsampling factor out of range");
endmodule

//--- sim/wisd_smp_src.sv
// Converter sample source feeding the discriminator
`timescale 1ns/1ps
module wisd_smp_src (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic en,
  input wire logic [wisd_pkg::SAMPLE_W-1:0] re,
  input wire logic [wisd_pkg::SAMPLE_W-1:0] im,
  output logic [wisd_pkg::SAMPLE_W-1:0] smp_re,
  output logic [wisd_pkg::SAMPLE_W-1:0] smp_im,
  output logic smp_valid
);
  import wisd_pkg::*;
  // Lines flip between samples so stale data never passes for a sample
  always_ff @(posedge mclk) begin
    smp_valid <= en & ~sys_rst;
    smp_re <= sys_rst ? '0 : (en ? re : ~smp_re);
    smp_im <= sys_rst ? '0 : (en ? im : ~smp_im);
  end
endmodule

//--- sim/wisd_core_bench.sv
// Self-checking bench of the weighted integration discriminator
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module wisd_core_bench;
  import wisd_pkg::*;
  localparam int LEN_V = 8;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic log_ready = 1'b0;
  logic src_en = 1'b0;
  logic [15:0] s_re = 16'h0;
  logic [15:0] s_im = 16'h0;
  logic [31:0] reg_rdata;
  logic [SAMPLE_W-1:0] smp_re;
  logic [SAMPLE_W-1:0] smp_im;
  logic smp_valid;
  logic [LOG_W-1:0] log_data;
  logic [UIDX_W-1:0] log_unit;
  logic log_valid;
  logic [NUNIT-1:0] state_bits;
  logic busy;
  logic [31:0] v;
  logic [LOG_W+1:0] expq[$];
  logic [7:0] ra [5] = '{REG_LEN, REG_DSF, REG_ASSIGN, REG_THR0, 8'hFC};
  logic [31:0] rv [5] = '{32'h10, 32'h1, 32'hF, 32'h0, 32'h0};
  int miscompares = 0;
  int n_checks = 0;
  always #50 mclk = ~mclk;
  wisd_smp_src wisd_smp_src_i (.mclk(mclk), .sys_rst(sys_rst), .en(src_en), .re(s_re),
    .im(s_im), .smp_re(smp_re), .smp_im(smp_im), .smp_valid(smp_valid));
  wisd_core wisd_core_i (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .smp_re(smp_re), .smp_im(smp_im), .smp_valid(smp_valid), .log_data(log_data),
    .log_unit(log_unit), .log_valid(log_valid), .log_ready(log_ready),
    .state_bits(state_bits), .busy(busy));
  task automatic complete_run();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    @(posedge mclk);
  endtask
  // Weights stay constant over the window, so each sum is count times one product
  task automatic run(input logic [31:0] ctrl, input logic [4:0] d, input int nlog);
    logic signed [15:0] sr;
    logic signed [15:0] si;
    logic signed [15:0] wre;
    logic signed [15:0] wim;
    logic signed [63:0] e [NUNIT];
    logic signed [31:0] t;
    logic [NUNIT-1:0] sb;
    logic [NUNIT-1:0] m;
    int k;
    sr = $signed(12'($urandom));
    si = $signed(12'($urandom));
    s_re <= sr;
    s_im <= si;
    m = ctrl[CTRL_MULTI] ? 4'h7 : 4'hF;
    for (int u = 0; u < NUNIT; u++) begin
      wre = $signed(12'($urandom));
      wim = $signed(12'($urandom));
      e[u] = LEN_V * (64'(sr) * wre - 64'(si) * wim);
      wr(REG_WADDR, 32'(u) << 12);
      for (int i = 0; i < LEN_V; i++) begin
        wr(REG_WDATA, {wre, wim});
      end
    end
    if (ctrl[CTRL_MULTI]) begin
      e[2] = e[1] - e[0];
    end
    for (int u = 0; u < NUNIT; u++) begin
      t = 32'(e[u]) + 32'($urandom_range(2)) - 32'd1;
      wr(REG_THR0 + 8'(4 * u), t);
      sb[u] = !(e[u] > 64'(t));
      if (u < nlog) begin
        expq.push_back({2'(u), e[u][LOG_W-1:0]});
      end
    end
    wr(REG_DSF, 32'(d));
    wr(REG_LEN, LEN_V);
    wr(REG_CTRL, ctrl | 32'h1);
    src_en <= 1'b1;
    repeat (LEN_V * d) @(posedge mclk);
    src_en <= 1'b0;
    #1 k = 0;
    while (busy !== 1'b0 && k < 300) begin
      @(posedge mclk);
      #1 k++;
    end
    `CHK("busy", 1'b0, busy)
    rd(REG_STATE);
    `CHK("state", sb & m, v[3:0] & m)
  endtask
  task automatic drain();
    logic [LOG_W+1:0] x;
    int k;
    log_ready <= 1'b1;
    while (expq.size() > 0) begin
      x = expq.pop_front();
      k = 0;
      while (log_valid !== 1'b1 && k < 50) begin
        @(posedge mclk);
        #1 k++;
      end
      `CHK("log_unit", x[LOG_W+1:LOG_W], log_unit)
      `CHK("log_data", x[LOG_W-1:0], log_data)
      @(posedge mclk);
      #1;
    end
    log_ready <= 1'b0;
    `CHK("log_extra", 1'b0, log_valid)
  endtask
  initial begin
    void'($urandom(32'h9ECFB6AF));
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    for (int i = 0; i < 5; i++) begin
      rd(ra[i]);
      `CHK("reset value", rv[i], v)
    end
    wr(REG_DSF, 32'h0);
    rd(REG_DSF);
    `CHK("dsf low", 32'(DSF_MIN), v)
    wr(REG_DSF, 32'h11);
    rd(REG_DSF);
    `CHK("dsf high", 32'(DSF_MAX), v)
    run(32'h28, 5'h1, 4);
    run(32'h28, 5'h1, 4);
    rd(REG_STATUS);
    // Eight results: seven queued plus one in the output register, one slot left
    `CHK("fifo room", 1'b1, v[3])
    `CHK("log pending", 1'b1, v[2])
    drain();
    run(32'h3C, 5'h1, 2);
    drain();
    run(32'h2A, 5'h2, 4);
    drain();
    run(32'h2A, 5'h10, 4);
    drain();
    complete_run();
  end
  // A hang in any handshake ends the run as a failure
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    complete_run();
  end
endmodule
bind wisd_core wisd_core_props wisd_core_props_i (.mclk(mclk), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .smp_re(smp_re), .smp_im(smp_im), .smp_valid(smp_valid),
  .log_data(log_data), .log_unit(log_unit), .log_valid(log_valid), .log_ready(log_ready),
  .state_bits(state_bits), .busy(busy));
